// >>> design/ioa_addr_calc.sv
// Purpose: Combinational effective address for one file operand
// Assumes: Mode and pointers are already registered by the caller
// Notes:   Pure logic, no state
`timescale 1ns/100ps
`default_nettype none
module ioa_addr_calc
    import ioa_pkg::*;
(
    // Mode and pointers
    input  wire logic        ext_en,
    input  wire logic [3:0]  bank_sel,
    input  wire logic [11:0] frame_ptr,
    // Operand in, address out
    input  wire ioa_req_s    req,
    output var  ioa_ans_s    ans
);

    logic is_idx;
    logic [12:0] sum;

    always_comb begin
        is_idx = ext_en && !req.access_sel && (req.file_op <= IOA_OFFSET_LIMIT);
        sum    = {1'b0, frame_ptr} + {5'h00, req.file_op};
        ans.indexed  = is_idx;
        ans.dest_sel = req.dest_sel;
        if (is_idx) begin
            ans.addr = sum[11:0];
        end else if (req.access_sel) begin
            ans.addr = {bank_sel, req.file_op};
        end else if (req.file_op > IOA_OFFSET_LIMIT) begin
            ans.addr = {IOA_SFR_BANK, req.file_op};
        end else begin
            ans.addr = {4'h0, req.file_op};
        end
    end

endmodule : ioa_addr_calc
`default_nettype wire

// >>> design/ioa_operand_addr.sv
// Purpose: Operand address generator between decode and data memory
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes:   Address path is combinational; status latches last request
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ioa_operand_addr
    import ioa_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        SYS_RST,
    // Decode side
    input  wire logic        OP_VALID,
    input  wire logic [7:0]  OP_FILE,
    input  wire logic        OP_ACCESS,
    input  wire logic        OP_DEST,
    // Memory side
    output logic [11:0]      MEM_ADDR,
    output logic             MEM_INDEXED,
    output logic             MEM_DEST,
    // AXI4-Lite write
    input  wire logic [31:0] AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [31:0] ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);

    logic        ext_en_q;
    logic [3:0]  bank_q;
    logic [11:0] frame_q;
    logic [13:0] status_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic [3:0]  aw_addr_q;
    logic        aw_top_ok_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    ioa_req_s    req;
    ioa_ans_s    ans;

    assign req = '{file_op: OP_FILE, access_sel: OP_ACCESS, dest_sel: OP_DEST};

    ioa_addr_calc u_calc (
        .ext_en    (ext_en_q),
        .bank_sel  (bank_q),
        .frame_ptr (frame_q),
        .req       (req),
        .ans       (ans)
    );

    // Same-cycle answer so the read happens in the decode cycle
    assign MEM_ADDR    = ans.addr;
    assign MEM_INDEXED = ans.indexed;
    assign MEM_DEST    = ans.dest_sel;

    // Last taken request, visible to software
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            status_q <= '0;
        end else if (OP_VALID) begin
            status_q <= {ans.dest_sel, ans.indexed, ans.addr};
        end
    end

    // Write channel capture, either order
    logic do_write;
    assign AWREADY  = !aw_got_q && !BVALID;
    assign WREADY   = !w_got_q && !BVALID;
    assign do_write = aw_got_q && w_got_q && !BVALID;

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            aw_got_q    <= 1'b0;
            aw_addr_q   <= 4'h0;
            aw_top_ok_q <= 1'b0;
        end else if (AWVALID && AWREADY) begin
            aw_got_q    <= 1'b1;
            aw_addr_q   <= AWADDR[3:0];
            // Upper bits kept as one flag so aliases of the map are refused
            aw_top_ok_q <= (AWADDR[31:4] == 28'h0000000);
        end else if (do_write) begin
            aw_got_q    <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            w_got_q  <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (WVALID && WREADY) begin
            w_got_q  <= 1'b1;
            w_data_q <= WDATA;
            w_strb_q <= WSTRB;
        end else if (do_write) begin
            w_got_q  <= 1'b0;
        end
    end

    logic wr_hit;
    logic wr_en;
    assign wr_hit = aw_top_ok_q && ((aw_addr_q == IOA_REG_CTRL) || (aw_addr_q == IOA_REG_BANK)
                 || (aw_addr_q == IOA_REG_FRAME));
    // Unmapped writes answer SLVERR and leave every register alone
    assign wr_en  = do_write && wr_hit;

    // Extension enable is the sole mode control
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ext_en_q <= IOA_EXT_RST;
        end else if (wr_en && aw_addr_q == IOA_REG_CTRL && w_strb_q[0]) begin
            ext_en_q <= w_data_q[IOA_CTRL_EXT_BIT];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            bank_q <= IOA_BANK_RST;
        end else if (wr_en && aw_addr_q == IOA_REG_BANK && w_strb_q[0]) begin
            bank_q <= w_data_q[3:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            frame_q <= IOA_FRAME_RST;
        end else if (wr_en && aw_addr_q == IOA_REG_FRAME) begin
            if (w_strb_q[0]) begin
                frame_q[7:0] <= w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
                frame_q[11:8] <= w_data_q[11:8];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            BVALID <= 1'b0;
            BRESP  <= IOA_RESP_OKAY;
        end else if (do_write) begin
            BVALID <= 1'b1;
            BRESP  <= wr_hit ? IOA_RESP_OKAY : IOA_RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    bresp_hold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (BVALID && !BREADY) |=> BVALID && $stable(BRESP))
        else $error("Write response dropped early");

    write_answer_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        do_write |=> BVALID)
        else $error("Write response missing");

    bad_write_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (do_write && !wr_hit) |=> BRESP == IOA_RESP_SLVERR
            && $stable(ext_en_q) && $stable(bank_q) && $stable(frame_q))
        else $error("Unmapped write not refused");

    wready_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        BVALID |-> !AWREADY && !WREADY)
        else $error("Write accepted while response pending");

    // Read channel
    assign ARREADY = !RVALID;

    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (ARADDR[3:0])
            IOA_REG_CTRL:   rd_word[IOA_CTRL_EXT_BIT] = ext_en_q;
            IOA_REG_BANK:   rd_word[3:0]  = bank_q;
            IOA_REG_FRAME:  rd_word[11:0] = frame_q;
            IOA_REG_STATUS: rd_word[13:0] = status_q;
            default:        rd_hit = 1'b0;
        endcase
        if (ARADDR[31:4] != 28'h0000000) begin
            rd_hit  = 1'b0;
            rd_word = 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RVALID <= 1'b0;
            RDATA  <= 32'h0000_0000;
            RRESP  <= IOA_RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RDATA  <= rd_word;
            RRESP  <= rd_hit ? IOA_RESP_OKAY : IOA_RESP_SLVERR;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end

    rdata_hold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (RVALID && !RREADY) |=> RVALID && $stable(RDATA) && $stable(RRESP))
        else $error("Read data dropped early");

    arready_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        RVALID |-> !ARREADY)
        else $error("Read accepted while data pending");

    read_answer_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ARVALID && ARREADY) |=> RVALID)
        else $error("Read data missing");

    bad_read_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ARVALID && ARREADY && ARADDR[31:4] != 28'h0000000)
            |=> RRESP == IOA_RESP_SLVERR && RDATA == 32'h0000_0000)
        else $error("Unmapped read not refused");

    // Checks
    logic [12:0] chk_sum;
    assign chk_sum = {1'b0, frame_q} + {5'h00, OP_FILE};

    literal_mode_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (!ext_en_q && OP_ACCESS) |-> MEM_ADDR == {bank_q, OP_FILE})
        else $error("Banked literal address wrong");

    literal_access_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (!ext_en_q && !OP_ACCESS && OP_FILE <= IOA_OFFSET_LIMIT)
            |-> MEM_ADDR == {4'h0, OP_FILE})
        else $error("Access bank low address wrong");

    indexed_addr_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ext_en_q && !OP_ACCESS && OP_FILE <= IOA_OFFSET_LIMIT)
            |-> MEM_ADDR == chk_sum[11:0] && MEM_INDEXED)
        else $error("Indexed address wrong");

    mode_follows_ext_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        MEM_INDEXED |-> ext_en_q)
        else $error("Indexed mode without extension");

    access_bit_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        OP_ACCESS |-> !MEM_INDEXED)
        else $error("Indexed mode with access bit set");

    high_operand_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ext_en_q && !OP_ACCESS && OP_FILE > IOA_OFFSET_LIMIT) |-> !MEM_INDEXED
            && MEM_ADDR == {IOA_SFR_BANK, OP_FILE})
        else $error("High operand reinterpreted");

    zero_frame_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ext_en_q && frame_q == 12'h000 && !OP_ACCESS && OP_FILE <= IOA_OFFSET_LIMIT)
            |-> MEM_ADDR == {4'h0, OP_FILE})
        else $error("Zero frame not backward compatible");

    dest_pass_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        MEM_DEST == OP_DEST)
        else $error("Destination bit altered");

    status_track_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        OP_VALID |=> status_q[11:0] == $past(MEM_ADDR))
        else $error("Status address not captured");

    status_hold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !OP_VALID |=> $stable(status_q))
        else $error("Status changed without request");

    ext_banked_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (ext_en_q && OP_ACCESS) |-> MEM_ADDR == {bank_q, OP_FILE} && !MEM_INDEXED)
        else $error("Banked address wrong in extended mode");

    access_high_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (!ext_en_q && !OP_ACCESS && OP_FILE > IOA_OFFSET_LIMIT)
            |-> MEM_ADDR == {IOA_SFR_BANK, OP_FILE})
        else $error("Access bank high address wrong");

    ctrl_write_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (wr_en && aw_addr_q == IOA_REG_CTRL && w_strb_q[0])
            |=> ext_en_q == w_data_q[IOA_CTRL_EXT_BIT])
        else $error("Extension enable not written");

    bank_write_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (wr_en && aw_addr_q == IOA_REG_BANK && w_strb_q[0]) |=> bank_q == w_data_q[3:0])
        else $error("Bank select not written");

    frame_write_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (wr_en && aw_addr_q == IOA_REG_FRAME && w_strb_q[1:0] == 2'b11)
            |=> frame_q == w_data_q[11:0])
        else $error("Frame pointer not written");

endmodule : ioa_operand_addr
`default_nettype wire

// >>> design/ioa_pkg.sv
// Purpose: Shared constants and carriers for operand address generation
// Assumes: 12-bit data address space, 8-bit file operand
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave
package ioa_pkg;

    localparam int          IOA_ADDR_W       = 12;
    localparam logic [7:0]  IOA_OFFSET_LIMIT = 8'h5F;
    localparam logic [7:0]  IOA_ACCESS_HI    = 8'hF0;
    localparam logic [3:0]  IOA_SFR_BANK     = 4'hF;

    // Register map
    localparam logic [3:0]  IOA_REG_CTRL     = 4'h0;
    localparam logic [3:0]  IOA_REG_BANK     = 4'h4;
    localparam logic [3:0]  IOA_REG_FRAME    = 4'h8;
    localparam logic [3:0]  IOA_REG_STATUS   = 4'hC;

    // Field positions
    localparam int          IOA_CTRL_EXT_BIT = 0;
    localparam int          IOA_ST_IDX_BIT   = 12;
    localparam int          IOA_ST_DEST_BIT  = 13;

    // Reset values
    localparam logic        IOA_EXT_RST      = 1'b0;
    localparam logic [3:0]  IOA_BANK_RST     = 4'h0;
    localparam logic [11:0] IOA_FRAME_RST    = 12'h000;

    localparam logic [1:0]  IOA_RESP_OKAY    = 2'b00;
    localparam logic [1:0]  IOA_RESP_SLVERR  = 2'b10;

    typedef struct packed {
        logic [7:0] file_op;
        logic       access_sel;
        logic       dest_sel;
    } ioa_req_s;

    typedef struct packed {
        logic [11:0] addr;
        logic        indexed;
        logic        dest_sel;
    } ioa_ans_s;

endpackage : ioa_pkg

// >>> test/ioa_decode_model.sv
// Purpose: Decode-stage model splitting a byte or bit instruction word
// Assumes: File operand in [7:0], access bit in [8], destination in [9]
// Notes:   Bit instructions carry a bit number in [11:9]; dest is then don't-care
`timescale 1ns/100ps
`default_nettype none
module ioa_decode_model (
    // Instruction word
    input  wire logic [15:0] instr,
    // Fields to the address block
    output logic [7:0]       file_op,
    output logic             access_sel,
    output logic             dest_sel
);
    assign file_op    = instr[7:0];
    assign access_sel = instr[8];
    assign dest_sel   = instr[9];
endmodule : ioa_decode_model
`default_nettype wire

// >>> test/tb.sv
// Purpose: Self-checking bench for the operand address generator
// Assumes: Registers at byte addresses 0h, 4h, 8h, Ch; full write strobes
// Notes:   Expected addresses come from an integer model, not from the design
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ioa_pkg::*;
    logic CLK_SYS = 0, SYS_RST = 1, OP_VALID = 0;
    logic [15:0] instr = 16'h0000;
    logic [7:0] OP_FILE;
    logic OP_ACCESS, OP_DEST, MEM_INDEXED, MEM_DEST;
    logic [11:0] MEM_ADDR;
    logic [31:0] AWADDR = 0, WDATA = 0, ARADDR = 0, RDATA, s, d;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP, r;
    logic [13:0] e;
    logic [13:0] exp_q[$];
    int err_total = 0, comparisons = 0, ext, bank, frame, f;
    always #2 CLK_SYS = ~CLK_SYS;
    ioa_decode_model u_dec (.instr(instr), .file_op(OP_FILE), .access_sel(OP_ACCESS),
                            .dest_sel(OP_DEST));
    ioa_operand_addr dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .OP_VALID(OP_VALID),
        .OP_FILE(OP_FILE), .OP_ACCESS(OP_ACCESS), .OP_DEST(OP_DEST), .MEM_ADDR(MEM_ADDR),
        .MEM_INDEXED(MEM_INDEXED), .MEM_DEST(MEM_DEST), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // Reference mapping, integers only
    function automatic logic [13:0] model(input int x, b, fp, fo, a, dd);
        int ad, ix;
        ix = (x != 0 && a == 0 && fo <= 'h5F);
        if (ix != 0) ad = (fp + fo) % 4096;
        else if (a != 0) ad = b * 256 + fo;
        else if (fo >= 'h60) ad = 'hF00 + fo;
        else ad = fo;
        return {dd[0], ix[0], ad[11:0]};
    endfunction : model
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic timeout_hit(input int n);
        if (n >= 100) begin
            err_total++;
            $display("MISMATCH handshake expected answer seen none");
        end
    endtask : timeout_hit
    // Entered just after a rising edge; leaves just after one
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] dv, output logic [1:0] rs);
        logic aw, w;
        int n;
        aw = 1;
        w = 1;
        n = 0;
        AWADDR <= a;
        WDATA <= dv;
        AWVALID <= 1;
        WVALID <= 1;
        BREADY <= 1;
        while (n < 100) begin
            @(posedge CLK_SYS);
            n++;
            if (!aw && !w && BVALID === 1'b1) break;
            if (aw && AWREADY === 1'b1) begin
                aw = 0;
                AWVALID <= 0;
            end
            if (w && WREADY === 1'b1) begin
                w = 0;
                WVALID <= 0;
            end
        end
        rs = BRESP;
        BREADY <= 0;
        // Idle edge so the next call never re-raises BREADY in this step
        @(posedge CLK_SYS);
        timeout_hit(n);
    endtask : axi_wr
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] dv, output logic [1:0] rs);
        logic ar;
        int n;
        ar = 1;
        n = 0;
        ARADDR <= a;
        ARVALID <= 1;
        RREADY <= 1;
        while (n < 100) begin
            @(posedge CLK_SYS);
            n++;
            if (!ar && RVALID === 1'b1) break;
            if (ar && ARREADY === 1'b1) begin
                ar = 0;
                ARVALID <= 0;
            end
        end
        dv = RDATA;
        rs = RRESP;
        RREADY <= 0;
        @(posedge CLK_SYS);
        timeout_hit(n);
    endtask : axi_rd
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // Whole run needs a few hundred cycles
    initial begin
        #100000;
        err_total++;
        finish_test();
    end
    initial begin
        s = 32'hD001;
        repeat (2) @(posedge CLK_SYS);
        SYS_RST <= 0;
        @(posedge CLK_SYS);
        for (int k = 0; k < 4; k++) begin
            axi_rd(k * 4, d, r);
            chk("reset value", 32'h0, d);
        end
        axi_rd(32'h10, d, r);
        chk("unmapped read resp", {30'h0, IOA_RESP_SLVERR}, {30'h0, r});
        chk("unmapped read data", 32'h0, d);
        axi_wr(32'h10, 32'hFFFF_FFFF, r);
        chk("unmapped write resp", {30'h0, IOA_RESP_SLVERR}, {30'h0, r});
        axi_rd({28'h0, IOA_REG_CTRL}, d, r);
        chk("ctrl after unmapped write", 32'h0, d);
        $display("test registers done");
        for (int c = 0; c < 6; c++) begin
            s = lfsr(s);
            ext = c % 2;
            bank = s[15:12];
            frame = (c < 2) ? 0 : (c < 4) ? 'hFC0 : s[11:0];
            axi_wr({28'h0, IOA_REG_CTRL}, ext, r);
            chk("ctrl write resp", {30'h0, IOA_RESP_OKAY}, {30'h0, r});
            axi_wr({28'h0, IOA_REG_BANK}, bank, r);
            chk("bank write resp", {30'h0, IOA_RESP_OKAY}, {30'h0, r});
            axi_wr({28'h0, IOA_REG_FRAME}, frame, r);
            chk("frame write resp", {30'h0, IOA_RESP_OKAY}, {30'h0, r});
            axi_rd({28'h0, IOA_REG_CTRL}, d, r);
            chk("ctrl readback", ext, d);
            axi_rd({28'h0, IOA_REG_FRAME}, d, r);
            chk("frame readback", frame, d);
            for (int i = 0; i < 40; i++) begin
                s = lfsr(s);
                case (i)
                    0: f = 'h5F;
                    1: f = 'h60;
                    2: f = 'h00;
                    3: f = 'hFF;
                    default: f = s[7:0];
                endcase
                @(posedge CLK_SYS);
                instr <= {s[15:8], f[7:0]};
                OP_VALID <= (i % 8 == 7);
                #1;
                e = model(ext, bank, frame, f, s[8], s[9]);
                chk("MEM_ADDR", e[11:0], MEM_ADDR);
                chk("MEM_INDEXED", e[12], MEM_INDEXED);
                chk("MEM_DEST", e[13], MEM_DEST);
                if (i % 8 == 7) begin
                    exp_q.push_back(e);
                    @(posedge CLK_SYS);
                    OP_VALID <= 0;
                    axi_rd({28'h0, IOA_REG_STATUS}, d, r);
                    chk("status", {18'h0, exp_q.pop_front()}, d);
                end
            end
            $display("test mode %0d frame %h done", ext, frame);
        end
        finish_test();
    end
endmodule : tb
`default_nettype wire
